// *** design/bml_fifo.sv ***
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Small FIFO with a registered output stage
// ============================================================
module bml_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_sys_rst,
  // Stream
  bml_stream_if.fifo s
);
  import bml_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;       // Storage
    logic [AW-1:0]               wr_ptr;    // Next write slot
    logic [AW-1:0]               rd_ptr;    // Next read slot
    logic [AW:0]                 count;     // Words in storage
    logic                        out_valid; // Output stage loaded
    logic [WIDTH-1:0]            out_data;  // Output stage word
  } bml_fifo_s;

  bml_fifo_s r_reg;
  bml_fifo_s r_next;
  logic      do_push;
  logic      do_pull;

  // Ready only reflects stored words, so full is honest
  assign s.push_ready = (r_reg.count != FULL_CNT);
  assign s.pop_valid  = r_reg.out_valid;
  assign s.pop_data   = r_reg.out_data;

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    r_next  = r_reg;
    do_push = s.push_valid && (r_reg.count != FULL_CNT);
    do_pull = (r_reg.count != '0) && (!r_reg.out_valid || s.pop_ready);
    // Output stage drains on accept
    if (s.pop_ready && r_reg.out_valid) begin
      r_next.out_valid = 1'b0;
    end
    // Refill output stage from storage
    if (do_pull) begin
      r_next.out_valid = 1'b1;
      r_next.out_data  = r_reg.mem[r_reg.rd_ptr];
      r_next.rd_ptr    = AW'(r_reg.rd_ptr + 1'b1);
    end
    // Store incoming word
    if (do_push) begin
      r_next.mem[r_reg.wr_ptr] = s.push_data;
      r_next.wr_ptr            = AW'(r_reg.wr_ptr + 1'b1);
    end
    // Occupancy
    if (do_push && !do_pull) begin
      r_next.count = (AW+1)'(r_reg.count + 1'b1);
    end else if (!do_push && do_pull) begin
      r_next.count = (AW+1)'(r_reg.count - 1'b1);
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule
`default_nettype wire

// *** design/bml_loader.sv ***
`timescale 1ns/1ns
`default_nettype none
module bml_loader (
  // Clock and reset
  input  wire logic                    i_clock,
  input  wire logic                    i_sys_rst,
  // Boot straps and memory select pin
  input  wire logic                    i_eprom_boot_strap,
  input  wire logic                    i_link_boot_strap,
  input  wire logic                    i_boot_memory_select,
  output logic                         o_boot_memory_select,
  output logic                         o_boot_memory_select_oe,
  input  wire logic                    i_bus_owner,
  // Boot source
  input  wire logic [bml_pkg::CHUNK_W-1:0] i_src_data,
  input  wire logic                    i_src_strobe,
  input  wire logic                    i_host_16bit,
  output logic                         o_src_ready,
  // DMA write toward internal memory
  output logic                         o_dma_valid,
  output logic [bml_pkg::ADDR_W-1:0]   o_dma_addr,
  output logic [bml_pkg::WORD_W-1:0]   o_dma_data,
  input  wire logic                    i_dma_ready,
  output logic [3:0]                   o_dma_channel,
  // Core status
  output logic [2:0]                   o_boot_mode,
  output logic                         o_core_run,
  output logic                         o_exec_external
);
  import bml_pkg::*;

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic               eb_s1, eb_s2;      // Strap synchronisers
    logic               lb_s1, lb_s2;
    logic               sel_s1, sel_s2;
    logic               w16_s1, w16_s2;    // Host width synchroniser
    logic [CHUNK_W-1:0] data_s1, data_s2;  // Source data synchroniser
    logic               stb_s1, stb_s2, stb_s3;
    logic [1:0]         settle;            // Post-reset settle count
    bml_state_e         state;
    bml_mode_e          mode;              // Latched boot mode
    logic               wide;              // Host bus is 16 bits
    logic [3:0]         chan;              // DMA channel / link buffer
    logic [CHUNK_W-1:0] rx_buf;            // Serial receive buffer
    logic               rx_full;
    logic [WORD_W-1:0]  word;              // Word being packed
    logic [3:0]         nchunks;           // Chunks in word
    logic [3:0]         target;            // Chunks per word
    logic [8:0]         pushed;            // Words handed to FIFO
    logic [8:0]         written;           // Words taken by DMA
    logic               src_ready;
    logic               sel_out;
    logic               sel_oe;
    logic               core_run;
    logic               exec_ext;
  } bml_loader_s;

  bml_loader_s r_reg;
  bml_loader_s r_next;
  logic        strobe_rise;   // New chunk from source
  logic        word_full;     // Packed word waiting to push
  bml_mode_e   strap_mode;    // Decode of synchronised straps

  bml_stream_if fifo_if ();

  // Buffer between packer and DMA; full FIFO stalls the source
  bml_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .s         (fifo_if.fifo)
  );

  assign strobe_rise        = r_reg.stb_s2 && !r_reg.stb_s3;
  assign word_full          = (r_reg.state == ST_LOAD) && (r_reg.nchunks == r_reg.target);
  assign strap_mode         = bml_decode(r_reg.eb_s2, r_reg.lb_s2, r_reg.sel_s2);
  assign fifo_if.push_valid = word_full;
  assign fifo_if.push_data  = {ADDR_W'(BOOT_BASE + {11'h0, r_reg.pushed}), r_reg.word};
  assign fifo_if.pop_ready  = i_dma_ready;

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    r_next = r_reg;
    // Two-flop synchronisers for pins
    r_next.eb_s1   = i_eprom_boot_strap;
    r_next.eb_s2   = r_reg.eb_s1;
    r_next.lb_s1   = i_link_boot_strap;
    r_next.lb_s2   = r_reg.lb_s1;
    r_next.sel_s1  = i_boot_memory_select;
    r_next.sel_s2  = r_reg.sel_s1;
    r_next.w16_s1  = i_host_16bit;
    r_next.w16_s2  = r_reg.w16_s1;
    r_next.data_s1 = i_src_data;
    r_next.data_s2 = r_reg.data_s1;
    r_next.stb_s1  = i_src_strobe;
    r_next.stb_s2  = r_reg.stb_s1;
    r_next.stb_s3  = r_reg.stb_s2;

    // DMA accepts count toward completion
    if (fifo_if.pop_valid && i_dma_ready) begin
      r_next.written = 9'(r_reg.written + 1'b1);
    end

    unique case (r_reg.state)
      // Wait for synchronisers, then latch the mode once
      ST_SETTLE: begin
        if (r_reg.settle == SETTLE_LAST) begin
          r_next.mode   = strap_mode;
          r_next.wide   = r_reg.w16_s2;
          r_next.target = bml_chunks(strap_mode, r_reg.w16_s2);
          unique case (strap_mode)
            BML_EPROM: r_next.chan = CHAN_EXT;
            BML_HOST:  r_next.chan = CHAN_EXT;
            BML_LINK:  r_next.chan = LINK_BUF;
            BML_SPI:   r_next.chan = CHAN_SPI;
            BML_NONE:  r_next.chan = 4'h0;
          endcase
          if (strap_mode == BML_NONE) begin
            r_next.state    = ST_RUN;
            r_next.core_run = 1'b1;
            r_next.exec_ext = 1'b1;
          end else begin
            r_next.state = ST_LOAD;
          end
        end else begin
          r_next.settle = 2'(r_reg.settle + 1'b1);
        end
      end
      // Capture, pack and push until the kernel is queued
      ST_LOAD: begin
        if (strobe_rise && r_reg.src_ready) begin
          r_next.rx_buf  = r_reg.data_s2;
          r_next.rx_full = 1'b1;
        end
        if (r_reg.rx_full && !word_full) begin
          r_next.word    = bml_shift(r_reg.word, r_reg.rx_buf, r_reg.mode, r_reg.wide);
          r_next.nchunks = 4'(r_reg.nchunks + 1'b1);
          r_next.rx_full = 1'b0;
        end
        if (word_full && fifo_if.push_ready) begin
          r_next.nchunks = 4'h0;
          r_next.pushed  = 9'(r_reg.pushed + 1'b1);
          if (r_reg.pushed == BOOT_WORDS - 9'h1) begin
            r_next.state = ST_DRAIN;
          end
        end
      end
      // Let the DMA finish the last buffered words
      ST_DRAIN: begin
        if (r_reg.written == BOOT_WORDS) begin
          r_next.state    = ST_RUN;
          r_next.core_run = 1'b1;
        end
      end
      // Booted; mode stays until the next reset
      ST_RUN: begin
        r_next.state = ST_RUN;
      end
    endcase

    // Source may send only when a slot is free; FIFO full holds it off
    r_next.src_ready = (r_next.state == ST_LOAD) && !r_next.rx_full &&
                       (r_next.nchunks != r_next.target);

    // Memory select: active-low chip select, driven only by bus owner
    r_next.sel_out = !((r_next.state == ST_LOAD) || (r_next.state == ST_DRAIN));
    r_next.sel_oe  = (r_next.mode == BML_EPROM) && i_bus_owner &&
                     ((r_next.state == ST_LOAD) || (r_next.state == ST_DRAIN));
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      r_reg         <= '0;
      r_reg.sel_out <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // Outputs, all from flops
  // ==========================================================
  assign o_boot_memory_select    = r_reg.sel_out;
  assign o_boot_memory_select_oe = r_reg.sel_oe;
  assign o_src_ready             = r_reg.src_ready;
  assign o_dma_valid             = fifo_if.pop_valid;
  assign o_dma_addr              = fifo_if.pop_data[FIFO_W-1:WORD_W];
  assign o_dma_data              = fifo_if.pop_data[WORD_W-1:0];
  assign o_dma_channel           = r_reg.chan;
  assign o_boot_mode             = r_reg.mode;
  assign o_core_run              = r_reg.core_run;
  assign o_exec_external         = r_reg.exec_ext;

  // ==========================================================
  // Assertions
  // ==========================================================
  sequence s_spi_capture;
    (r_reg.state == ST_LOAD) && (r_reg.mode == BML_SPI) && strobe_rise && r_reg.src_ready;
  endsequence

  sequence s_settle_end;
    (r_reg.state == ST_SETTLE) && (r_reg.settle == SETTLE_LAST);
  endsequence

  property p_eprom_chan;
    @(posedge i_clock) disable iff (i_sys_rst)
      ((r_reg.state == ST_LOAD) && (r_reg.mode == BML_EPROM)) |-> (r_reg.chan == CHAN_EXT);
  endproperty
  a_eprom_chan: assert property (p_eprom_chan) else $error("EPROM boot not on external DMA");

  property p_select_active;
    @(posedge i_clock) disable iff (i_sys_rst)
      o_boot_memory_select_oe |-> (!o_boot_memory_select && (r_reg.mode == BML_EPROM));
  endproperty
  a_select_active: assert property (p_select_active) else $error("Select driven but not asserted");

  property p_select_release;
    @(posedge i_clock) disable iff (i_sys_rst)
      (r_reg.state == ST_RUN) |-> !o_boot_memory_select_oe;
  endproperty
  a_select_release: assert property (p_select_release) else $error("Select still driven after boot");

  property p_owner_only;
    @(posedge i_clock) disable iff (i_sys_rst)
      (!i_bus_owner) |=> !o_boot_memory_select_oe;
  endproperty
  a_owner_only: assert property (p_owner_only) else $error("Select driven without bus ownership");

  property p_decode;
    @(posedge i_clock) disable iff (i_sys_rst)
      s_settle_end |=> (r_reg.mode == bml_decode($past(r_reg.eb_s2), $past(r_reg.lb_s2), $past(r_reg.sel_s2)));
  endproperty
  a_decode: assert property (p_decode) else $error("Boot mode differs from straps");

  property p_no_boot;
    @(posedge i_clock) disable iff (i_sys_rst)
      (s_settle_end ##0 (strap_mode == BML_NONE)) |=> (o_core_run && o_exec_external && !o_src_ready);
  endproperty
  a_no_boot: assert property (p_no_boot) else $error("No-boot did not start externally");

  property p_spi_capture;
    @(posedge i_clock) disable iff (i_sys_rst)
      s_spi_capture |=> (r_reg.rx_full && (r_reg.rx_buf == $past(r_reg.data_s2)) && (o_dma_channel == CHAN_SPI));
  endproperty
  a_spi_capture: assert property (p_spi_capture) else $error("Serial word not held in buffer");

  property p_link_nibbles;
    @(posedge i_clock) disable iff (i_sys_rst)
      ((r_reg.state == ST_LOAD) && (r_reg.mode == BML_LINK)) |-> ((r_reg.target == CHUNKS_4) && (r_reg.chan == LINK_BUF));
  endproperty
  a_link_nibbles: assert property (p_link_nibbles) else $error("Link boot setup wrong");

  property p_pack_hold;
    @(posedge i_clock) disable iff (i_sys_rst)
      (word_full && !fifo_if.push_ready) |=> ($stable(r_reg.word) && word_full);
  endproperty
  a_pack_hold: assert property (p_pack_hold) else $error("Packed word lost under back-pressure");

  property p_run_after_load;
    @(posedge i_clock) disable iff (i_sys_rst)
      ((r_reg.state == ST_DRAIN) && (r_reg.written == BOOT_WORDS)) |=> (o_core_run && !o_exec_external);
  endproperty
  a_run_after_load: assert property (p_run_after_load) else $error("Core not started after 256 words");

  property p_mode_fixed;
    @(posedge i_clock) disable iff (i_sys_rst)
      ((r_reg.state != ST_SETTLE) && ($past(r_reg.state) != ST_SETTLE)) |-> $stable(r_reg.mode);
  endproperty
  a_mode_fixed: assert property (p_mode_fixed) else $error("Boot mode changed after sampling");

endmodule
`default_nettype wire

// *** design/bml_pkg.sv ***
// ============================================================
// Boot mode select loader: shared constants, types, helpers
// ============================================================
package bml_pkg;

  // ==========================================================
  // Widths and sizes
  // ==========================================================
  localparam int WORD_W     = 48;            // Instruction word width
  localparam int ADDR_W     = 20;            // Internal address width
  localparam int CHUNK_W    = 16;            // Widest incoming chunk
  localparam int FIFO_DEPTH = 8;             // Words buffered toward DMA
  localparam int FIFO_W     = ADDR_W + WORD_W;

  // ==========================================================
  // Load figures
  // ==========================================================
  localparam logic [8:0]        BOOT_WORDS = 9'h100;      // Kernel length
  localparam logic [ADDR_W-1:0] BOOT_BASE  = 20'h40000;   // First word address
  localparam logic [1:0]        SETTLE_LAST = 2'h2;       // Strap sync settle
  localparam logic [3:0]        CHAN_EXT   = 4'ha;        // External port DMA
  localparam logic [3:0]        CHAN_SPI   = 4'h8;        // Serial DMA channel
  localparam logic [3:0]        LINK_BUF   = 4'h4;        // Link buffer number
  localparam logic [3:0]        CHUNKS_8   = 4'h6;        // Bytes per word
  localparam logic [3:0]        CHUNKS_16  = 4'h3;        // Halfwords per word
  localparam logic [3:0]        CHUNKS_4   = 4'hc;        // Nibbles per word

  // ==========================================================
  // Enumerations
  // ==========================================================
  typedef enum logic [2:0] {
    BML_NONE,
    BML_EPROM,
    BML_HOST,
    BML_LINK,
    BML_SPI
  } bml_mode_e;

  typedef enum logic [1:0] {
    ST_SETTLE,
    ST_LOAD,
    ST_DRAIN,
    ST_RUN
  } bml_state_e;

  // ==========================================================
  // Helpers
  // ==========================================================
  // Strap decode; both straps high is reserved and boots nothing
  function automatic bml_mode_e bml_decode(input logic e_strap, input logic l_strap, input logic sel);
    bml_mode_e m;
    m = BML_NONE;
    if (e_strap && !l_strap) begin
      m = BML_EPROM;
    end else if (!e_strap && !l_strap) begin
      m = sel ? BML_HOST : BML_NONE;
    end else if (!e_strap && l_strap) begin
      m = sel ? BML_LINK : BML_SPI;
    end
    return m;
  endfunction

  // Chunks that make one instruction word
  function automatic logic [3:0] bml_chunks(input bml_mode_e m, input logic wide);
    logic [3:0] c;
    c = CHUNKS_8;
    if (m == BML_LINK) begin
      c = CHUNKS_4;
    end else if (m == BML_HOST && wide) begin
      c = CHUNKS_16;
    end
    return c;
  endfunction

  // Shift one chunk in at the top; first chunk ends lowest
  function automatic logic [WORD_W-1:0] bml_shift(input logic [WORD_W-1:0] w,
                                                  input logic [CHUNK_W-1:0] c,
                                                  input bml_mode_e m,
                                                  input logic wide);
    logic [WORD_W-1:0] r;
    r = {c[7:0], w[WORD_W-1:8]};
    if (m == BML_LINK) begin
      r = {c[3:0], w[WORD_W-1:4]};
    end else if (m == BML_HOST && wide) begin
      r = {c, w[WORD_W-1:16]};
    end
    return r;
  endfunction

endpackage

// *** design/bml_stream_if.sv ***
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Word stream between loader and its FIFO
// ============================================================
interface bml_stream_if;
  import bml_pkg::*;
  logic              push_valid;  // Packed word offered
  logic              push_ready;  // FIFO has room
  logic [FIFO_W-1:0] push_data;   // Address and word
  logic              pop_valid;   // Word waiting for DMA
  logic              pop_ready;   // DMA takes it
  logic [FIFO_W-1:0] pop_data;    // Registered word out

  modport user (output push_valid, output push_data, input push_ready,
                input pop_valid, input pop_data, output pop_ready);
  modport fifo (input push_valid, input push_data, output push_ready,
                output pop_valid, output pop_data, input pop_ready);
endinterface
`default_nettype wire

// *** testbench/bml_src_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Boot source: strobes chunks while the loader asks
// ============================================================
module bml_src_model (
  // Clock and control
  input  wire logic        i_clock,
  input  wire logic        i_go,
  input  wire logic        i_ready,
  input  wire logic        i_slow,
  input  wire logic [15:0] i_salt,
  // Source pins
  output logic [15:0]      o_data,
  output logic             o_strobe
);
  int n; // Chunks sent since go rose

  // One chunk per strobe; data held until ready falls
  initial begin
    o_data = 16'h0;
    o_strobe = 1'b0;
    n = 0;
    forever begin
      @(posedge i_clock);
      #2;
      if (!i_go) begin
        n = 0;
      end else if (i_ready) begin
        o_data = 16'(n) * 16'h9e37 ^ i_salt;
        o_strobe = 1'b1;
        while (i_ready) @(negedge i_clock);
        @(posedge i_clock);
        #2;
        // Released data flips so stale values cannot pass
        o_strobe = 1'b0;
        o_data = ~o_data;
        n++;
        repeat (i_slow ? 5 : 2) @(posedge i_clock);
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/boot_mode_select_loader_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Bench: each loading boot mode loaded end to end, then both no-boot strap sets
// ============================================================
module boot_mode_select_loader_tb;
  import bml_pkg::*;
  logic        clock, rst, e_strap, l_strap, sel_in, owner, h16, dma_rdy, go, slow, stall;
  logic        strobe, src_rdy, sel_out, sel_oe, dvalid, run, ext;
  logic [15:0] salt, src_data;
  logic [19:0] daddr;
  logic [47:0] ddata;
  logic [3:0]  chan;
  logic [2:0]  mode;
  wire logic   sel_pin = sel_oe ? sel_out : sel_in; // Board level when released
  int          failures, checked, seed, words, cw, saw_oe, lo;

  bml_loader i_bml_loader (.i_clock(clock), .i_sys_rst(rst), .i_eprom_boot_strap(e_strap),
    .i_link_boot_strap(l_strap), .i_boot_memory_select(sel_pin), .o_boot_memory_select(sel_out),
    .o_boot_memory_select_oe(sel_oe), .i_bus_owner(owner), .i_src_data(src_data),
    .i_src_strobe(strobe), .i_host_16bit(h16), .o_src_ready(src_rdy), .o_dma_valid(dvalid),
    .o_dma_addr(daddr), .o_dma_data(ddata), .i_dma_ready(dma_rdy), .o_dma_channel(chan),
    .o_boot_mode(mode), .o_core_run(run), .o_exec_external(ext));
  bml_src_model i_bml_src_model (.i_clock(clock), .i_go(go), .i_ready(src_rdy), .i_slow(slow),
    .i_salt(salt), .o_data(src_data), .o_strobe(strobe));

  task automatic check_value(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Word k packed LSB chunk first from the source pattern
  function automatic logic [47:0] exp_word(input int k);
    logic [47:0] w;
    logic [15:0] c;
    w = 48'h0;
    for (int j = 0; j < 48 / cw; j++) begin
      c = 16'(k * (48 / cw) + j) * 16'h9e37 ^ salt;
      w = w | ((48'(c) & ((48'h1 << cw) - 48'h1)) << (j * cw));
    end
    return w;
  endfunction

  task automatic print_verdict;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Pin and DMA monitor, then random stall and bus ownership
  always @(posedge clock) begin
    // Outputs are unknown until the first reset edge
    if ($time > 10) begin
      check_value(64'(sel_oe & (mode != BML_EPROM)), 64'h0);
    end
    if (lo >= 4) begin
      check_value(64'(sel_oe), 64'h0);
    end
    if (sel_oe === 1'b1) begin
      saw_oe = 1;
      check_value(64'(sel_out), 64'h0);
    end
    if (dvalid === 1'b1 && dma_rdy === 1'b1) begin
      check_value(64'(daddr), 64'(BOOT_BASE) + 64'(words));
      check_value(64'(ddata), 64'(exp_word(words)));
      words++;
    end
    #2;
    // Long stall fills the FIFO so back-pressure is exercised
    dma_rdy = !stall && (($random(seed) & 3) != 0);
    if (($random(seed) & 63) == 0) begin
      owner = ~owner;
    end
    slow = ($random(seed) & 3) == 0;
    lo = owner ? 0 : lo + 1;
  end

  // Reset with given straps, then load until the core runs
  task automatic run_mode(input logic [2:0] straps, input logic wide, input bml_mode_e m,
                          input logic [3:0] ch, input int w);
    int t;
    @(posedge clock);
    #2;
    {e_strap, l_strap, sel_in} = straps;
    h16 = wide;
    cw = w;
    rst = 1'b1;
    go = 1'b0;
    salt = 16'($random(seed));
    repeat (20) @(posedge clock);
    #2;
    rst = 1'b0;
    words = 0;
    saw_oe = 0;
    repeat (6) @(posedge clock);
    check_value(64'(mode), 64'(m));
    check_value(64'(chan), 64'(ch));
    check_value(64'({run, ext}), (m == BML_NONE) ? 64'h3 : 64'h0);
    #2;
    go = 1'b1;
    for (t = 0; t < 60000 && run !== 1'b1; t++) begin
      @(posedge clock);
      #2;
      stall = (t >= 1000) && (t < 2200);
      if (t == 700) begin
        {e_strap, l_strap} = ~straps[2:1];
      end
    end
    check_value(64'(words), (m == BML_NONE) ? 64'h0 : 64'h100);
    check_value(64'({run, sel_oe, mode}), 64'({2'b10, 3'(m)}));
    check_value(64'(saw_oe), 64'(m == BML_EPROM));
  endtask

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Clean run needs about 70k cycles; give up at 95k
  initial begin
    #1900000;
    failures++;
    print_verdict;
  end

  initial begin
    seed = 32'h706ca706;
    {rst, e_strap, l_strap, sel_in, owner, h16, dma_rdy, go, slow, stall} = 10'h200;
    {failures, checked, words, cw, saw_oe, lo} = '0;
    salt = 16'h0;
    run_mode(3'b100, 1'b0, BML_EPROM, CHAN_EXT, 8);
    run_mode(3'b001, 1'b0, BML_HOST, CHAN_EXT, 8);
    run_mode(3'b001, 1'b1, BML_HOST, CHAN_EXT, 16);
    run_mode(3'b011, 1'b0, BML_LINK, LINK_BUF, 4);
    run_mode(3'b010, 1'b0, BML_SPI, CHAN_SPI, 8);
    run_mode(3'b000, 1'b0, BML_NONE, 4'h0, 8);
    run_mode(3'b111, 1'b0, BML_NONE, 4'h0, 8);
    print_verdict;
  end
endmodule
`default_nettype wire
